// ===== hw/qspi_pkg.sv
/*
  Shared constants, types and the transfer-length decode for the queued
  serial engine. Assumes a 16-entry queue of 16-bit words.
*/
package qspi_pkg;

  localparam int unsigned PTR_W       = 4;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned LEN_W       = 4;
  localparam int unsigned CS_W        = 4;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned QUEUE_DEPTH = 16;

  localparam logic [PTR_W-1:0] WRAP_ZERO_PTR = 4'h0;
  localparam logic [LEN_W-1:0] LEN_CODE_16   = 4'h0;
  localparam logic [CNT_W-1:0] BITS_MAX      = 5'h10;
  localparam logic [CNT_W-1:0] BITS_BASE     = 5'h08;
  localparam logic [CS_W-1:0]  PORT_DATA_RST = 4'h0;

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_ACTIVE,
    RUN_HALTED
  } runState_t;

  // Reserved codes fall back to the 16-bit length
  function automatic logic [CNT_W-1:0] xferBits(input logic [LEN_W-1:0] code);
    logic [CNT_W-1:0] bits;
    bits = BITS_MAX;
    if (code[3]) begin
      bits = BITS_BASE + {2'h0, code[2:0]};
    end
    return bits;
  endfunction : xferBits

  function automatic logic [PTR_W-1:0] nextEntry(input logic [PTR_W-1:0] p);
    return p + 4'h1;
  endfunction : nextEntry

endpackage : qspi_pkg

// ===== hw/qspi_slave_shifter.sv
/*
  Serial-clock side of the slave path: shifts one bit per clock pulse while
  the select is low and toggles a flag at each completed word.
  Assumes the transmit word and length code are held stable by the system
  side for the whole word, and that the master launches on the rising edge
  and samples on the falling edge.
*/
`timescale 1ns/1ps
module qspi_slave_shifter (
  // Link
  input  wire logic                           sck,
  input  wire logic                           slaveSelectN,
  input  wire logic                           mosi,
  output logic                                miso,
  // From system side, quasi-static
  input  wire logic                           srst,
  input  wire logic [qspi_pkg::LEN_W-1:0]    transferLength,
  input  wire logic [qspi_pkg::WORD_W-1:0]   txWord,
  // To system side
  output logic [qspi_pkg::WORD_W-1:0]         rxWord,
  output logic                                doneTgl
);
  import qspi_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] shift;
  } shiftState_t;

  shiftState_t       s;
  shiftState_t       next_s;
  logic [CNT_W-1:0]  lenBits;
  logic              lastBit;
  logic [WORD_W-1:0] inWord;
  logic [3:0]        txIdx;

  always_comb begin
    lenBits = xferBits(transferLength);
    lastBit = (s.cnt == lenBits - 5'h01);
    inWord  = {s.shift[WORD_W-2:0], mosi};
    txIdx   = 4'(lenBits - 5'h01 - s.cnt);
    next_s  = s;
    next_s.cnt   = s.cnt + 5'h01;
    next_s.shift = inWord;
    if (lastBit) begin
      // Past 16 bits the count simply rolls into the next entry
      next_s.cnt   = '0;
      next_s.shift = '0;
    end
  end

  // Select high abandons a partial word; the entry is retried
  always_ff @(negedge sck or posedge slaveSelectN or posedge srst) begin
    if (srst || slaveSelectN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(negedge sck or posedge srst) begin
    if (srst) begin
      doneTgl <= 1'b0;
      rxWord  <= '0;
    end else if (!slaveSelectN && lastBit) begin
      doneTgl <= ~doneTgl;
      rxWord  <= inWord;
    end
  end

  always_ff @(posedge sck or posedge slaveSelectN) begin
    if (slaveSelectN) begin
      miso <= 1'b0;
    end else begin
      miso <= txWord[txIdx];
    end
  end

endmodule : qspi_slave_shifter

// ===== hw/queued_spi_wrap_slave_cs.sv
/*
  Queue walker of the queued serial engine: wrap-around, halt, slave queue
  walk, peripheral chip-select drive and mode fault.
  Assumes an external master shifter pulses masterXferDone per entry, and
  that the serial clock half period exceeds four system clocks so the next
  transmit word is ready in time.
*/
// Operation
// - Wrap active whenever wrap_enable set
// - Wrap restarts at zero or new pointer
// - Wrapping keeps cycling and enable stays set
// - Each pass overwrites receive RAM entries
// - Done flag set at end, software clears
// - Irq enable buffered; clearing keeps pending request
// - Wrap cleared: next end sets flag, stops
// - Halt finishes current transfer then stops
// - Master select clear means passive slave
// - Select low starts slave at new pointer
// - Slave ignores commands, drives no selects
// - Length per entry; then advance pointers
// - Advanced pointer used unless new pointer written
// - One bit per clock; early release retries entry
// - Over 16 bits advances without select toggle
// - Slave continues until queue end
// - Slave end sets flag, irq, maybe stops
// - Master entry drives chip selects from command
// - Select low in master mode faults only while own select undriven
// - Idle chip-select level from port data
// - Length code 0000 is 16, 1xxx 8-15
`timescale 1ns/1ps
module queued_spi_wrap_slave_cs (
  // Clock, reset, enable
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire logic                           ce,
  // Configuration
  input  wire logic                           masterSelect,
  input  wire logic                           wrapEnable,
  input  wire logic                           wrapTargetSelect,
  input  wire logic                           halt,
  input  wire logic                           queueDoneIrqEnable,
  input  wire logic [qspi_pkg::LEN_W-1:0]    transferLength,
  input  wire logic [qspi_pkg::PTR_W-1:0]    endQueuePointer,
  input  wire logic [qspi_pkg::CS_W-1:0]     portData,
  // Commands
  input  wire logic                           engineEnableSet,
  input  wire logic                           engineEnableClear,
  input  wire logic [qspi_pkg::PTR_W-1:0]    newQueuePointer,
  input  wire logic                           newQueuePointerWrite,
  input  wire logic                           queueDoneFlagClear,
  input  wire logic                           modeFaultClear,
  // Queue RAM access
  input  wire logic                           txWrite,
  input  wire logic                           cmdWrite,
  input  wire logic [qspi_pkg::PTR_W-1:0]    ramAddr,
  input  wire logic [qspi_pkg::WORD_W-1:0]   txData,
  input  wire logic [qspi_pkg::CS_W-1:0]     cmdData,
  input  wire logic [qspi_pkg::PTR_W-1:0]    rxReadAddr,
  output logic [qspi_pkg::WORD_W-1:0]         rxReadData,
  // Master shifter handshake
  input  wire logic                           masterXferDone,
  input  wire logic [qspi_pkg::WORD_W-1:0]   masterRxData,
  output logic                                masterReq,
  // Status
  output logic                                engineEnable,
  output logic                                queueDoneFlag,
  output logic                                queueDoneIrq,
  output logic [qspi_pkg::PTR_W-1:0]          completedQueuePointer,
  output logic [qspi_pkg::PTR_W-1:0]          workingQueuePointer,
  output logic                                halted,
  output logic                                modeFault,
  // Link
  input  wire logic                           sck,
  input  wire logic                           slaveSelectN,
  input  wire logic                           mosi,
  output logic                                miso,
  output logic                                misoOe,
  output logic [qspi_pkg::CS_W-1:0]           pcsOut,
  output logic [qspi_pkg::CS_W-1:0]           pcsOe
);
  import qspi_pkg::*;

  typedef struct packed {
    logic [QUEUE_DEPTH-1:0][WORD_W-1:0] txRam;
    logic [QUEUE_DEPTH-1:0][WORD_W-1:0] rxRam;
    logic [QUEUE_DEPTH-1:0][CS_W-1:0]   cmdRam;
    logic [WORD_W-1:0]                  txWord;
    logic [WORD_W-1:0]                  rxReadData;
    runState_t                          runState;
    logic                               engineEnable;
    logic [PTR_W-1:0]                   ptr;
    logic [PTR_W-1:0]                   completed;
    logic                               doneFlag;
    logic                               irq;
    logic                               modeFault;
    logic                               masterReq;
    logic                               misoOe;
    logic [CS_W-1:0]                    pcsOut;
    logic [CS_W-1:0]                    pcsOe;
    logic                               ssMeta;
    logic                               ssSync;
    logic                               doneMeta;
    logic                               doneSync;
    logic                               donePrev;
    logic                               halted;
    logic [1:0]                         ownSelHist;
  } state_t;

  state_t            s;
  state_t            next_s;
  logic [WORD_W-1:0] rxWord;
  logic              doneTgl;
  logic              slaveOn;
  logic              wordDone;
  logic              stepEv;
  logic              atEnd;
  logic              setDone;
  logic              faultEv;

  qspi_slave_shifter qspi_slave_shifter_inst (
    .sck            (sck),
    .slaveSelectN   (slaveSelectN),
    .mosi           (mosi),
    .miso           (miso),
    .srst           (srst),
    .transferLength (transferLength),
    .txWord         (s.txWord),
    .rxWord         (rxWord),
    .doneTgl        (doneTgl)
  );

  always_comb begin
    next_s = s;
    // Inverted before sync so reset reads as not selected
    next_s.ssMeta   = ~slaveSelectN;
    next_s.ssSync   = s.ssMeta;
    next_s.doneMeta = doneTgl;
    next_s.doneSync = s.doneMeta;
    next_s.donePrev = s.doneSync;
    wordDone = s.doneSync ^ s.donePrev;
    slaveOn  = ~masterSelect;

    if (txWrite) begin
      next_s.txRam[ramAddr] = txData;
    end
    if (cmdWrite) begin
      next_s.cmdRam[ramAddr] = cmdData;
    end

    // Slave steps on completed words; master on its shifter's done
    stepEv = (s.runState == RUN_ACTIVE) &&
             (slaveOn ? wordDone : (masterXferDone && s.masterReq));
    atEnd   = (s.ptr == endQueuePointer);
    setDone = stepEv && atEnd;

    if (stepEv) begin
      next_s.rxRam[s.ptr] = slaveOn ? rxWord : masterRxData;
      next_s.completed    = s.ptr;
      next_s.ptr          = nextEntry(s.ptr);
      if (atEnd) begin
        if (wrapEnable) begin
          next_s.ptr = wrapTargetSelect ? newQueuePointer : WRAP_ZERO_PTR;
        end else begin
          next_s.engineEnable = 1'b0;
          next_s.runState     = RUN_IDLE;
        end
      end
      if (halt && next_s.runState == RUN_ACTIVE) begin
        next_s.runState = RUN_HALTED;
      end
    end else if (s.runState == RUN_ACTIVE && halt && slaveOn && !s.ssSync) begin
      // Between frames nothing is in flight
      next_s.runState = RUN_HALTED;
    end else if (s.runState == RUN_HALTED && !halt) begin
      next_s.runState = RUN_ACTIVE;
    end

    // A fresh pointer from software overrides the advanced one
    if (newQueuePointerWrite) begin
      next_s.ptr = newQueuePointer;
    end
    if (engineEnableSet) begin
      next_s.engineEnable = 1'b1;
      next_s.runState     = halt ? RUN_HALTED : RUN_ACTIVE;
      next_s.ptr          = newQueuePointer;
    end
    // Clearing mid-transfer may abort it; accepted as documented hazard
    if (engineEnableClear) begin
      next_s.engineEnable = 1'b0;
      next_s.runState     = RUN_IDLE;
    end

    // Set wins over clear
    if (setDone) begin
      next_s.doneFlag = 1'b1;
    end else if (queueDoneFlagClear) begin
      next_s.doneFlag = 1'b0;
    end
    if (setDone && queueDoneIrqEnable) begin
      next_s.irq = 1'b1;
    end else if (queueDoneFlagClear) begin
      // Only the flag clear withdraws a request, not the enable
      next_s.irq = 1'b0;
    end

    // Own select release needs two syncs to settle, else false fault
    next_s.ownSelHist = {s.ownSelHist[0], s.pcsOe[0]};
    faultEv = masterSelect && s.ssSync && !s.pcsOe[0] &&
              (s.ownSelHist == 2'h0);
    if (faultEv) begin
      next_s.modeFault = 1'b1;
    end else if (modeFaultClear) begin
      next_s.modeFault = 1'b0;
    end

    next_s.txWord     = next_s.txRam[next_s.ptr];
    next_s.rxReadData = s.rxRam[rxReadAddr];
    next_s.masterReq  = masterSelect && !next_s.modeFault &&
                        (next_s.runState == RUN_ACTIVE);
    next_s.pcsOut     = next_s.masterReq ? next_s.cmdRam[next_s.ptr] : portData;
    if (!next_s.masterReq) begin
      next_s.pcsOut = portData;
    end
    next_s.pcsOe = (masterSelect && !next_s.modeFault && next_s.engineEnable) ?
                   {CS_W{1'b1}} : {CS_W{1'b0}};
    next_s.misoOe = slaveOn && next_s.engineEnable && next_s.ssSync;
    next_s.halted = (next_s.runState == RUN_HALTED);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  always_comb begin
    rxReadData            = s.rxReadData;
    masterReq             = s.masterReq;
    engineEnable          = s.engineEnable;
    queueDoneFlag         = s.doneFlag;
    queueDoneIrq          = s.irq;
    completedQueuePointer = s.completed;
    workingQueuePointer   = s.ptr;
    halted                = s.halted;
    modeFault             = s.modeFault;
    misoOe                = s.misoOe;
    pcsOut                = s.pcsOut;
    pcsOe                 = s.pcsOe;
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence sStepAtEnd;
    ce && stepEv && atEnd && !engineEnableClear && !engineEnableSet &&
    !newQueuePointerWrite;
  endsequence

  sequence sMidStep;
    ce && stepEv && !atEnd && !newQueuePointerWrite && !engineEnableSet;
  endsequence

  sequence sFaultSeen;
    ce && masterSelect && s.ssSync && !s.pcsOe[0] && s.ownSelHist == 2'h0;
  endsequence

  a_wrap_target: assert property (
    sStepAtEnd and wrapEnable |=>
      s.ptr == ($past(wrapTargetSelect) ? $past(newQueuePointer) : WRAP_ZERO_PTR))
    else $error("wrap pointer wrong");

  a_wrap_keeps_en: assert property (
    sStepAtEnd and wrapEnable |=> s.engineEnable && s.runState != RUN_IDLE)
    else $error("wrap cleared enable");

  a_end_sets_flag: assert property (
    sStepAtEnd |=> s.doneFlag ##1 (s.doneFlag || $past(queueDoneFlagClear)))
    else $error("done flag not set");

  a_irq_held: assert property (
    s.irq && !queueDoneFlagClear && ce |=> s.irq)
    else $error("irq dropped without flag clear");

  a_stop_nowrap: assert property (
    sStepAtEnd and !wrapEnable |=> !s.engineEnable && s.runState == RUN_IDLE)
    else $error("no stop at queue end");

  a_halt_stops: assert property (
    s.runState == RUN_HALTED && halt && ce && !engineEnableClear |=>
      s.runState == RUN_HALTED && $stable(s.completed))
    else $error("halted engine stepped");

  a_ptr_advance: assert property (
    sMidStep |=> s.ptr == nextEntry($past(s.ptr)) && s.completed == $past(s.ptr))
    else $error("pointer not advanced");

  a_slave_no_cs: assert property (
    !masterSelect && ce |=> s.pcsOe == '0 && !s.masterReq)
    else $error("slave drives chip selects");

  a_cs_level: assert property (
    s.masterReq |-> s.pcsOut == s.cmdRam[s.ptr])
    else $error("chip select level wrong");

  a_fault_latch: assert property (
    sFaultSeen |=> s.modeFault ##1 (s.pcsOe == '0))
    else $error("mode fault missed");

  a_fault_sticky: assert property (
    s.modeFault && !modeFaultClear && ce |=> s.modeFault)
    else $error("mode fault dropped");

  a_flag_sticky: assert property (
    s.doneFlag && !queueDoneFlagClear && ce |=> s.doneFlag)
    else $error("done flag dropped");

  a_irq_raise: assert property (
    ce && setDone && queueDoneIrqEnable |=> s.irq)
    else $error("irq not raised at queue end");

  a_enable_start: assert property (
    ce && engineEnableSet && !engineEnableClear |=>
      s.engineEnable && s.ptr == $past(newQueuePointer))
    else $error("enable did not load new pointer");

  a_new_ptr: assert property (
    ce && newQueuePointerWrite |=> s.ptr == $past(newQueuePointer))
    else $error("new pointer not taken");

  a_rx_store: assert property (
    ce && stepEv && !masterSelect |=> s.rxRam[$past(s.ptr)] == $past(rxWord))
    else $error("receive word not stored");

  a_idle_cs: assert property (
    ce ##1 !s.masterReq |-> s.pcsOut == $past(portData))
    else $error("idle chip select level wrong");

  a_master_no_miso: assert property (
    masterSelect && ce |=> !s.misoOe)
    else $error("master drives miso");

endmodule : queued_spi_wrap_slave_cs

// ===== bench/spi_master_model.sv
/*
  Behavioural SPI bus master on the far side of the slave link.
  Assumes a free-running 6 ns linkClk; sck is divided from it and stands
  still low between frames.
*/
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF = 30
) (
  // Link clock
  input  wire logic linkClk,
  // Bus
  input  wire logic miso,
  output logic      sck,
  output logic      selectN,
  output logic      mosi
);
  initial begin
    sck     = 1'b0;
    selectN = 1'b1;
    mosi    = 1'b1;
  end

  // Half period of 180 ns keeps the slave's word reload in time
  task automatic wait_half();
    repeat (HALF) @(posedge linkClk);
  endtask : wait_half

  // MSB first, launch on rising sck, sample on falling
  task automatic frame(input int nBits, input logic [31:0] dout, output logic [31:0] din);
    din = 32'h0;
    @(posedge linkClk);
    selectN = 1'b0;
    wait_half();
    for (int i = nBits - 1; i >= 0; i--) begin
      sck  = 1'b1;
      mosi = dout[i];
      wait_half();
      sck = 1'b0;
      din = {din[30:0], miso};
      wait_half();
    end
    selectN = 1'b1;
    // Released line shows the inverse so stale data is never trusted
    mosi = ~mosi;
  endtask : frame

  // Select low with no clocks, as a rival master would
  task automatic select_pulse(input int cycles);
    @(posedge linkClk);
    selectN = 1'b0;
    repeat (cycles) @(posedge linkClk);
    selectN = 1'b1;
  endtask : select_pulse
endmodule : spi_master_model

// ===== bench/queued_spi_wrap_slave_cs_test.sv
/*
  Self-checking bench for the queue walker: slave walk, wrap, halt,
  master chip selects and mode fault.
  Assumes the SPI master model on the link and a 6 ns link clock.
*/
`timescale 1ns/1ps
module queued_spi_wrap_slave_cs_test;
  import qspi_pkg::*;
  logic        clk_sys = 1'b0, linkClk = 1'b0, srst = 1'b0, ce = 1'b1;
  logic        masterSelect = 1'b0, wrapEnable = 1'b0, wrapTargetSelect = 1'b0, halt = 1'b0;
  logic        queueDoneIrqEnable = 1'b0, engineEnableSet = 1'b0, engineEnableClear = 1'b0;
  logic        newQueuePointerWrite = 1'b0, queueDoneFlagClear = 1'b0, modeFaultClear = 1'b0;
  logic        txWrite = 1'b0, cmdWrite = 1'b0, masterXferDone = 1'b0;
  logic [3:0]  transferLength = 4'h0, endQueuePointer = 4'h0, portData = 4'h0;
  logic [3:0]  newQueuePointer = 4'h0, ramAddr = 4'h0, cmdData = 4'h0, rxReadAddr = 4'h0;
  logic [15:0] txData = 16'h0, masterRxData = 16'h0, rxReadData;
  logic        masterReq, engineEnable, queueDoneFlag, queueDoneIrq, halted, modeFault;
  logic        miso, misoOe, sck, mosi, ssModel, slaveSelectN, misoLine;
  logic [3:0]  completedQueuePointer, workingQueuePointer, pcsOut, pcsOe;
  int          errorCnt = 0, testsRun = 0;

  always #20 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #3 linkClk = ~linkClk;
  end

  // Shared select pin: design drives it only with its enable up
  assign slaveSelectN = pcsOe[0] ? pcsOut[0] : ssModel;
  // Undriven miso toggles so a stale level never passes
  assign misoLine = misoOe ? miso : ~sck;

  queued_spi_wrap_slave_cs queued_spi_wrap_slave_cs_inst (
    .clk_sys, .srst, .ce, .masterSelect, .wrapEnable, .wrapTargetSelect, .halt,
    .queueDoneIrqEnable, .transferLength, .endQueuePointer, .portData,
    .engineEnableSet, .engineEnableClear, .newQueuePointer, .newQueuePointerWrite,
    .queueDoneFlagClear, .modeFaultClear, .txWrite, .cmdWrite, .ramAddr, .txData,
    .cmdData, .rxReadAddr, .rxReadData, .masterXferDone, .masterRxData, .masterReq,
    .engineEnable, .queueDoneFlag, .queueDoneIrq, .completedQueuePointer,
    .workingQueuePointer, .halted, .modeFault, .sck, .slaveSelectN, .mosi, .miso,
    .misoOe, .pcsOut, .pcsOe
  );

  spi_master_model spi_master_model_inst (
    .linkClk, .miso(misoLine), .sck, .selectN(ssModel), .mosi
  );

  function automatic logic [15:0] txPat(input int i);
    return {4{4'(i + 1)}};
  endfunction : txPat

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : reportAndStop

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse

  task automatic writeRam(input logic isCmd, input logic [3:0] a, input logic [15:0] d);
    ramAddr = a;
    txData  = d;
    cmdData = d[3:0];
    cmdWrite = isCmd;
    txWrite  = ~isCmd;
    tick();
    cmdWrite = 1'b0;
    txWrite  = 1'b0;
    // One idle edge so back-to-back writes never re-raise in one step
    tick();
  endtask : writeRam

  task automatic readRx(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] mask);
    rxReadAddr = a;
    tick(2);
    check(rxReadData & mask, exp);
  endtask : readRx

  task automatic enable(input logic [3:0] p);
    newQueuePointer = p;
    pulse(engineEnableSet);
  endtask : enable

  // Completion shows three system edges after the last bit
  task automatic frameChk(input int nb, input logic [31:0] dout, exp, mask);
    logic [31:0] din;
    spi_master_model_inst.frame(nb, dout, din);
    tick(6);
    check(din & mask, exp);
  endtask : frameChk

  task automatic waitReq();
    int n;
    n = 0;
    while (masterReq !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    if (n == 50) begin
      errorCnt++;
      reportAndStop();
    end
  endtask : waitReq

  initial begin
    // A real rising edge so the serial side's async reset fires
    #1;
    srst = 1'b1;
    tick(10);
    srst = 1'b0;
    tick();
    check({engineEnable, queueDoneFlag, halted, modeFault, misoOe, pcsOe}, 9'h0);
    for (int i = 0; i < 16; i++) writeRam(1'b0, 4'(i), txPat(i));
    endQueuePointer = 4'h6;
    transferLength  = 4'h8;
    enable(4'h1);
    frameChk(8, 32'hA5, 32'h22, 32'hFF);
    check(completedQueuePointer, 4'h1);
    check(workingQueuePointer, 4'h2);
    check(pcsOe, 4'h0);
    readRx(4'h1, 16'h00A5, 16'h00FF);
    newQueuePointer = 4'h3;
    pulse(newQueuePointerWrite);
    transferLength = 4'hF;
    frameChk(14, 32'h1555, 32'h2222, 32'h3FFF);
    check(workingQueuePointer, 4'h3);
    frameChk(15, 32'h2AAA, 32'h4444, 32'h7FFF);
    check({completedQueuePointer, workingQueuePointer}, 8'h34);
    readRx(4'h3, 16'h2AAA, 16'h7FFF);
    transferLength = 4'h0;
    frameChk(32, 32'hDEADBEEF, {txPat(4), txPat(5)}, 32'hFFFFFFFF);
    check({completedQueuePointer, workingQueuePointer}, 8'h56);
    readRx(4'h4, 16'hDEAD, 16'hFFFF);
    readRx(4'h5, 16'hBEEF, 16'hFFFF);
    queueDoneIrqEnable = 1'b1;
    frameChk(16, 32'h0F0F, txPat(6), 32'hFFFF);
    check({queueDoneFlag, queueDoneIrq, engineEnable}, 3'b110);
    frameChk(16, 32'h1234, 32'h0, 32'h0);
    readRx(4'h6, 16'h0F0F, 16'hFFFF);
    pulse(queueDoneFlagClear);
    check({queueDoneFlag, queueDoneIrq}, 2'b00);
    // Wrap-around, then leave it the recommended way
    wrapEnable      = 1'b1;
    endQueuePointer = 4'h1;
    enable(4'h0);
    frameChk(32, 32'h11112222, {txPat(0), txPat(1)}, 32'hFFFFFFFF);
    check({queueDoneFlag, queueDoneIrq, engineEnable}, 3'b111);
    check(workingQueuePointer, 4'h0);
    queueDoneIrqEnable = 1'b0;
    tick();
    check(queueDoneIrq, 1'b1);
    frameChk(16, 32'h3333, txPat(0), 32'hFFFF);
    readRx(4'h0, 16'h3333, 16'hFFFF);
    check(queueDoneFlag, 1'b1);
    pulse(queueDoneFlagClear);
    wrapTargetSelect = 1'b1;
    newQueuePointer  = 4'h1;
    frameChk(16, 32'h4444, txPat(1), 32'hFFFF);
    check({queueDoneFlag, queueDoneIrq, engineEnable}, 3'b101);
    check(workingQueuePointer, 4'h1);
    wrapEnable = 1'b0;
    frameChk(16, 32'h5555, txPat(1), 32'hFFFF);
    check({queueDoneFlag, engineEnable}, 2'b10);
    pulse(queueDoneFlagClear);
    // Halt lands mid-word; the word still completes
    wrapEnable      = 1'b1;
    endQueuePointer = 4'h3;
    enable(4'h0);
    fork
      frameChk(16, 32'h6666, txPat(0), 32'hFFFF);
      begin
        tick(40);
        halt = 1'b1;
      end
    join
    check({halted, workingQueuePointer}, 5'h11);
    frameChk(16, 32'h7777, 32'h0, 32'h0);
    check(workingQueuePointer, 4'h1);
    pulse(engineEnableClear);
    check(engineEnable, 1'b0);
    halt       = 1'b0;
    wrapEnable = 1'b0;
    // Master walk over two commands
    masterSelect    = 1'b1;
    portData        = 4'h5;
    endQueuePointer = 4'h1;
    writeRam(1'b1, 4'h0, 16'h000A);
    writeRam(1'b1, 4'h1, 16'h0003);
    enable(4'h0);
    waitReq();
    check({pcsOut, pcsOe}, 8'hAF);
    masterRxData = 16'h1234;
    pulse(masterXferDone);
    tick(2);
    waitReq();
    check(pcsOut, 4'h3);
    pulse(masterXferDone);
    tick(3);
    check({engineEnable, queueDoneFlag, modeFault}, 3'b010);
    check(pcsOut, 4'h5);
    readRx(4'h0, 16'h1234, 16'hFFFF);
    // Clock enable low freezes state, so the clear is ignored
    ce = 1'b0;
    pulse(queueDoneFlagClear);
    check(queueDoneFlag, 1'b1);
    ce = 1'b1;
    pulse(queueDoneFlagClear);
    spi_master_model_inst.select_pulse(200);
    tick(3);
    check(modeFault, 1'b1);
    enable(4'h0);
    tick(2);
    check({modeFault, pcsOe, masterReq}, 6'h20);
    pulse(modeFaultClear);
    tick(2);
    check({modeFault, pcsOe}, 5'h0F);
    pulse(engineEnableClear);
    tick(3);
    check(modeFault, 1'b0);
    reportAndStop();
  end
endmodule : queued_spi_wrap_slave_cs_test
